/* File: design/aocal_consts.svh */
// Constants of the offset and gain correction stage
// What this block does
// - Samples are handled as 24-bit bipolar values; unipolar and amplifier gain are applied digitally after correction.
// - The offset value resets to 000000h and the gain value to 800000h.
// - In unipolar mode negative results become zero and the result is doubled.
// - The two-bit amplifier gain field scales the result inside the correction.
// - Self offset calibration shorts the inputs and stores the raw sample as offset.
// - Self gain calibration applies the reference and stores 1/(raw - offset) as gain.
// - Calibration results are written automatically and used by all later conversions.
// - System calibration needs a host zero or full-scale input; the device stores the results itself.
// - The offset value is a signed two's complement number.
// - The gain value is unsigned with one integer and 23 fraction bits, 800000h being one.
// - The result register changes only when a new conversion completes.
`ifndef AOCAL_CONSTS_SVH
`define AOCAL_CONSTS_SVH

// Register word addresses
`define AOCAL_ADDR_CTRL 3'h0
`define AOCAL_ADDR_OFFSET 3'h1
`define AOCAL_ADDR_GAIN 3'h2
`define AOCAL_ADDR_DATA 3'h3

// Control register fields
`define AOCAL_CTRL_PGA_LSB 0
`define AOCAL_CTRL_UNI_BIT 2
`define AOCAL_CTRL_CMD_LSB 3
`define AOCAL_CTRL_BUSY_BIT 6

// Reset values
`define AOCAL_OFFSET_RST 24'h000000
`define AOCAL_GAIN_RST 24'h800000
`define AOCAL_CTRL_RST 3'h0

// Number formats
`define AOCAL_FRAC_BITS 23
`define AOCAL_RECIP_SAT 24'hFFFFFF

// Output range limits
`define AOCAL_UNI_MAX 32'sh0000FFFF
`define AOCAL_BIP_MAX 32'sh00007FFF
`define AOCAL_BIP_MIN (-32'sh00008000)

// Longest reciprocal run from start to done
`define AOCAL_RECIP_CYCLES 48

`endif

/* File: design/aocal_pkg.sv */
// Types shared by the correction stage modules
package aocal_pkg;

  // Calibration commands written to the control register
  typedef enum logic [2:0] {
    CAL_NONE = 3'b000,
    CAL_SELF_OFF = 3'b001,
    CAL_SELF_GAIN = 3'b010,
    CAL_SYS_OFF = 3'b011,
    CAL_SYS_GAIN = 3'b100
  } aocal_cmd_e;

  // Calibration sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DIV = 2'b10
  } aocal_state_e;

endpackage

/* File: design/aocal_recip.sv */
// Sequential reciprocal: quot = 2^(2W-2) / den, saturated to W bits
`timescale 1ns/1ps
`include "aocal_consts.svh"
module aocal_recip import aocal_pkg::*; #(
  parameter int W = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request
  input wire logic start,
  input wire logic signed [W:0] den,
  // Answer
  output logic done,
  output logic [W-1:0] quot
);
  localparam int NB = 2 * W - 1;

  logic busy;
  logic [5:0] cnt;
  logic [W-1:0] rem;
  logic [W-1:0] dsr;
  logic [W-1:0] q;
  logic [W:0] trial;
  logic [W-1:0] next_rem;
  logic next_bit;
  logic sat;

  // Small or negative divisors would overflow the quotient width
  assign sat = den[W] | (den[W-1:0] <= (W'(1) << (W-2)));

  // Restoring step; numerator is a single one followed by zeros
  always_comb begin
    trial = {rem, (cnt == 6'h00)};
    if (trial >= {1'b0, dsr}) begin
      next_rem = W'(trial - {1'b0, dsr});
      next_bit = 1'b1;
    end else begin
      next_rem = trial[W-1:0];
      next_bit = 1'b0;
    end
  end

  // Iteration control
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy <= 1'b0;
      cnt <= 6'h00;
      rem <= '0;
      dsr <= '0;
      q <= '0;
      done <= 1'b0;
      quot <= '0;
    end else begin
      done <= 1'b0;
      if (start) begin
        if (sat) begin
          done <= 1'b1;
          quot <= `AOCAL_RECIP_SAT;
        end else begin
          busy <= 1'b1;
          dsr <= den[W-1:0];
          rem <= '0;
          q <= '0;
          cnt <= 6'h00;
        end
      end else if (busy) begin
        rem <= next_rem;
        q <= {q[W-2:0], next_bit};
        cnt <= cnt + 6'h01;
        if (cnt == 6'(NB - 1)) begin
          busy <= 1'b0;
          done <= 1'b1;
          quot <= {q[W-2:0], next_bit};
        end
      end
    end
  end
endmodule // aocal_recip

/* File: design/aocal_correct.sv */
// Offset subtraction, gain scaling, amplifier gain and output range
`timescale 1ns/1ps
`include "aocal_consts.svh"
module aocal_correct import aocal_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Sample and settings
  input wire logic in_valid,
  input wire logic [23:0] raw,
  input wire logic [23:0] offset,
  input wire logic [23:0] gain,
  input wire logic [1:0] programmable_amplifier,
  input wire logic unipolar,
  // Corrected result
  output logic out_valid,
  output logic [15:0] result
);
  logic signed [24:0] diff;
  logic signed [49:0] prod;
  logic signed [26:0] scaled;
  logic signed [31:0] shv;

  // Saturate a 24-bit scaled value to the 16-bit output code
  function automatic logic [15:0] sat16(input logic signed [31:0] v,
                                        input logic uni);
    logic signed [31:0] t;
    t = uni ? (v >>> 7) : (v >>> 8);
    if (uni) begin
      if (v < 0)
        sat16 = 16'h0000;
      else if (t > `AOCAL_UNI_MAX)
        sat16 = 16'hFFFF;
      else
        sat16 = t[15:0];
    end else begin
      if (t > `AOCAL_BIP_MAX)
        sat16 = 16'h7FFF;
      else if (t < `AOCAL_BIP_MIN)
        sat16 = 16'h8000;
      else
        sat16 = t[15:0];
    end
  endfunction

  // Bipolar datapath; offset signed, gain unsigned 1.23
  assign diff = $signed({raw[23], raw}) - $signed({offset[23], offset});
  assign prod = diff * $signed({1'b0, gain});
  assign scaled = prod[49:`AOCAL_FRAC_BITS];
  assign shv = 32'(scaled) <<< programmable_amplifier;

  // One register stage; unipolar doubling lives in sat16
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      result <= 16'h0000;
    end else begin
      out_valid <= in_valid;
      if (in_valid)
        result <= sat16(shv, unipolar);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  uni_floor_a: assert property (
    in_valid && unipolar && ($signed(raw) < $signed(offset))
    |=> result == 16'h0000)
    else $error("negative unipolar sample not floored");
  uni_double_a: assert property (
    in_valid && unipolar && programmable_amplifier == 2'h0 && gain == `AOCAL_GAIN_RST &&
    offset == 24'h000000 && raw == 24'h001000
    |=> result == 16'h0020)
    else $error("unipolar result not doubled");
  unity_pass_a: assert property (
    in_valid && !unipolar && programmable_amplifier == 2'h0 && gain == `AOCAL_GAIN_RST &&
    offset == 24'h000000 |=> result == $past(raw[23:8]))
    else $error("unity correction altered sample");
  pga_scale_a: assert property (
    in_valid && !unipolar && programmable_amplifier == 2'h1 && gain == `AOCAL_GAIN_RST &&
    offset == 24'h000000 && raw[23:21] == 3'h0
    |=> result == $past(raw[22:7]))
    else $error("amplifier gain of two not applied");
  sat_high_a: assert property (
    in_valid && !unipolar && programmable_amplifier == 2'h3 && gain == `AOCAL_GAIN_RST &&
    offset == 24'h000000 && raw == 24'h7FFFFF |=> result == 16'h7FFF)
    else $error("positive saturation missing");
endmodule // aocal_correct

/* File: design/aocal_top.sv */
// Offset and gain calibration stage with register port
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "aocal_consts.svh"
module aocal_top import aocal_pkg::*; (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Register port
  input wire logic [2:0] ADDR,
  input wire logic [23:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [23:0] RDATA,
  // Decimation filter samples
  input wire logic [23:0] RAW_DATA,
  input wire logic RAW_VALID,
  // Analog input conditioning
  output logic INPUT_SHORT,
  output logic INPUT_REF,
  // Status and result
  output logic CAL_BUSY,
  output logic [15:0] RESULT,
  output logic RESULT_VALID
);
  logic [23:0] offset;
  logic [23:0] gain;
  logic [1:0] programmable_amplifier;
  logic unipolar;
  aocal_cmd_e cal_cmd;
  aocal_state_e state;
  aocal_cmd_e wr_cmd;
  logic wr_ctrl;
  logic cal_start;
  logic take_sample;
  logic off_cal;
  logic gain_cal;
  logic div_start;
  logic signed [24:0] div_den;
  logic div_done;
  logic [23:0] div_quot;
  logic corr_in;
  logic corr_valid;
  logic [15:0] corr_result;

  // Command decode of a control write
  assign wr_ctrl = WR && (ADDR == `AOCAL_ADDR_CTRL);
  assign wr_cmd = aocal_cmd_e'(WDATA[`AOCAL_CTRL_CMD_LSB +: 3]);
  assign cal_start = wr_ctrl && (wr_cmd != CAL_NONE) && (state == ST_IDLE);

  // Which calibration consumes the next sample
  assign off_cal = (cal_cmd == CAL_SELF_OFF) || (cal_cmd == CAL_SYS_OFF);
  assign gain_cal = (cal_cmd == CAL_SELF_GAIN) || (cal_cmd == CAL_SYS_GAIN);
  assign take_sample = (state == ST_WAIT) && RAW_VALID;
  assign div_start = take_sample && gain_cal;
  assign div_den = $signed({RAW_DATA[23], RAW_DATA}) -
                   $signed({offset[23], offset});

  // Samples taken for calibration never reach the result register
  assign corr_in = RAW_VALID && (state == ST_IDLE);

  // Mode settings; takes effect on the next conversion only
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      programmable_amplifier <= 2'h0;
      unipolar <= 1'b0;
    end else if (wr_ctrl) begin
      programmable_amplifier <= WDATA[`AOCAL_CTRL_PGA_LSB +: 2];
      unipolar <= WDATA[`AOCAL_CTRL_UNI_BIT];
    end
  end

  // Calibration sequencer; unknown command codes are ignored
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state <= ST_IDLE;
      cal_cmd <= CAL_NONE;
      INPUT_SHORT <= 1'b0;
      INPUT_REF <= 1'b0;
      CAL_BUSY <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (cal_start && (wr_cmd <= CAL_SYS_GAIN)) begin
            state <= ST_WAIT;
            cal_cmd <= wr_cmd;
            CAL_BUSY <= 1'b1;
            INPUT_SHORT <= (wr_cmd == CAL_SELF_OFF);
            INPUT_REF <= (wr_cmd == CAL_SELF_GAIN);
          end
        end
        ST_WAIT: begin
          if (RAW_VALID) begin
            INPUT_SHORT <= 1'b0;
            if (off_cal) begin
              state <= ST_IDLE;
              cal_cmd <= CAL_NONE;
              CAL_BUSY <= 1'b0;
            end else begin
              state <= ST_DIV; // Reference stays applied, harmless
            end
          end
        end
        ST_DIV: begin
          INPUT_REF <= 1'b0;
          if (div_done) begin
            state <= ST_IDLE;
            cal_cmd <= CAL_NONE;
            CAL_BUSY <= 1'b0;
          end
        end
        default: begin
          state <= ST_IDLE;
          cal_cmd <= CAL_NONE;
          CAL_BUSY <= 1'b0;
          INPUT_SHORT <= 1'b0;
          INPUT_REF <= 1'b0;
        end
      endcase
    end
  end

  // Offset value; a calibration store wins over a host write
  always_ff @(posedge CLK) begin
    if (!RST_N)
      offset <= `AOCAL_OFFSET_RST;
    else if (take_sample && off_cal)
      offset <= RAW_DATA;
    else if (WR && ADDR == `AOCAL_ADDR_OFFSET)
      offset <= WDATA;
  end

  // Gain value; a finished reciprocal wins over a host write
  always_ff @(posedge CLK) begin
    if (!RST_N)
      gain <= `AOCAL_GAIN_RST;
    else if (div_done && state == ST_DIV)
      gain <= div_quot;
    else if (WR && ADDR == `AOCAL_ADDR_GAIN)
      gain <= WDATA;
  end

  // Reciprocal of the reference reading scaled so 2^23 means one
  aocal_recip #(
    .W(24)
  ) u_recip (
    .clk(CLK),
    .rst_n(RST_N),
    .start(div_start),
    .den(div_den),
    .done(div_done),
    .quot(div_quot)
  );

  // Correction of normal conversions
  aocal_correct u_correct (
    .clk(CLK),
    .rst_n(RST_N),
    .in_valid(corr_in),
    .raw(RAW_DATA),
    .offset(offset),
    .gain(gain),
    .programmable_amplifier(programmable_amplifier),
    .unipolar(unipolar),
    .out_valid(corr_valid),
    .result(corr_result)
  );

  // Result register only moves on a finished conversion
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      RESULT <= 16'h0000;
      RESULT_VALID <= 1'b0;
    end else begin
      RESULT_VALID <= corr_valid;
      if (corr_valid)
        RESULT <= corr_result;
    end
  end

  // Read data stands for one cycle; unmapped words read zero
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      RDATA <= 24'h000000;
    end else if (RD) begin
      case (ADDR)
        `AOCAL_ADDR_CTRL:
          RDATA <= {17'h00000, CAL_BUSY, cal_cmd, unipolar, programmable_amplifier};
        `AOCAL_ADDR_OFFSET: RDATA <= offset;
        `AOCAL_ADDR_GAIN: RDATA <= gain;
        `AOCAL_ADDR_DATA: RDATA <= {8'h00, RESULT};
        default: RDATA <= 24'h000000;
      endcase
    end else begin
      RDATA <= 24'h000000;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  reset_values_a: assert property (
    $rose(RST_N) |-> offset == `AOCAL_OFFSET_RST &&
                     gain == `AOCAL_GAIN_RST && RESULT == 16'h0000)
    else $error("correction values not at reset defaults");
  self_short_a: assert property (
    state == ST_WAIT && cal_cmd == CAL_SELF_OFF |-> INPUT_SHORT)
    else $error("inputs not shorted during self offset");
  gain_ref_a: assert property (
    state == ST_WAIT && cal_cmd == CAL_SELF_GAIN |-> INPUT_REF)
    else $error("reference not applied during self gain");
  offset_store_a: assert property (
    take_sample && off_cal |=> offset == $past(RAW_DATA) && !CAL_BUSY)
    else $error("offset sample not stored");
  gain_store_a: assert property (
    div_done && state == ST_DIV |=> gain == $past(div_quot) && !CAL_BUSY)
    else $error("reciprocal not stored as gain");
  recip_bound_a: assert property (
    div_start |-> ##[1:`AOCAL_RECIP_CYCLES] div_done)
    else $error("reciprocal took too long");
  result_hold_a: assert property (
    !corr_valid |=> $stable(RESULT) && !RESULT_VALID)
    else $error("result changed without a conversion");

  // A result only ever comes from the correction stage
  result_load_a: assert property (
    corr_valid |=> RESULT_VALID && RESULT == $past(corr_result))
    else $error("corrected sample not loaded into result");
  cal_no_result_a: assert property (
    RAW_VALID && state != ST_IDLE |-> ##2 !RESULT_VALID)
    else $error("calibration sample reached the result");
  data_read_a: assert property (
    RD && ADDR == `AOCAL_ADDR_DATA |=> RDATA == {8'h00, $past(RESULT)})
    else $error("result word not returned on read");

  // Command acceptance; a busy sequencer keeps its command
  cmd_latch_a: assert property (
    cal_start && wr_cmd <= CAL_SYS_GAIN
    |=> CAL_BUSY && state == ST_WAIT && cal_cmd == $past(wr_cmd))
    else $error("calibration command not taken");
  bad_cmd_a: assert property (
    cal_start && wr_cmd > CAL_SYS_GAIN |=> state == ST_IDLE && !CAL_BUSY)
    else $error("unknown command started a calibration");
  busy_ignore_a: assert property (
    wr_ctrl && state == ST_WAIT && !RAW_VALID
    |=> CAL_BUSY && cal_cmd == $past(cal_cmd))
    else $error("command replaced while busy");
  mode_write_a: assert property (
    wr_ctrl |=> programmable_amplifier == $past(WDATA[`AOCAL_CTRL_PGA_LSB +: 2]) &&
                unipolar == $past(WDATA[`AOCAL_CTRL_UNI_BIT]))
    else $error("amplifier gain or polarity not written");

  // Analog conditioning is released once its sample is in
  short_release_a: assert property (
    take_sample |=> !INPUT_SHORT)
    else $error("inputs still shorted after the sample");
  ref_release_a: assert property (
    state == ST_DIV |=> !INPUT_REF)
    else $error("reference still applied during the divide");
  sys_open_a: assert property (
    cal_cmd == CAL_SYS_OFF || cal_cmd == CAL_SYS_GAIN
    |-> !INPUT_SHORT && !INPUT_REF)
    else $error("system calibration altered the input");

  // The divider only runs inside a gain calibration
  gain_wait_a: assert property (
    take_sample && gain_cal |=> state == ST_DIV && CAL_BUSY)
    else $error("gain calibration did not start the divide");
  div_place_a: assert property (
    state != ST_DIV |-> !div_done)
    else $error("divider finished outside a gain calibration");

  // Stored values only move on a host write or a calibration store
  offset_hold_a: assert property (
    !WR && !take_sample |=> $stable(offset))
    else $error("offset value drifted");
  gain_hold_a: assert property (
    !WR && !(div_done && state == ST_DIV) |=> $stable(gain))
    else $error("gain value drifted");
  host_offset_a: assert property (
    WR && ADDR == `AOCAL_ADDR_OFFSET && !(take_sample && off_cal)
    |=> offset == $past(WDATA))
    else $error("host offset write lost");
  host_gain_a: assert property (
    WR && ADDR == `AOCAL_ADDR_GAIN && !(div_done && state == ST_DIV)
    |=> gain == $past(WDATA))
    else $error("host gain write lost");

  self_offset_c: cover property (take_sample && cal_cmd == CAL_SELF_OFF);
  self_gain_c: cover property (div_done && state == ST_DIV);
  uni_result_c: cover property (corr_valid && unipolar);
  sys_offset_c: cover property (take_sample && cal_cmd == CAL_SYS_OFF);
  bad_cmd_c: cover property (cal_start && wr_cmd > CAL_SYS_GAIN);
endmodule // aocal_top

/* File: verification/aocal_fe_model.sv */
// Behavioural front end: filter samples and the analog input state
`timescale 1ns/1ps
module aocal_fe_model #(
  parameter logic [23:0] SHORT_CODE = 24'h000100,
  parameter logic [23:0] REF_CODE = 24'h700100
) (
  // Clock
  input wire logic clk,
  // Sample request from the bench
  input wire logic go,
  input wire logic [23:0] ext_code,
  // Analog conditioning from the device
  input wire logic input_short,
  input wire logic input_ref,
  // Filter output
  output logic [23:0] raw_data,
  output logic raw_valid
);
  logic [23:0] code;
  logic [23:0] last = 24'h000000;

  // Shorted input reads the residual offset, reference reads near full scale
  always_comb begin
    if (input_short) begin
      code = SHORT_CODE;
    end else if (input_ref) begin
      code = REF_CODE;
    end else begin
      code = ext_code;
    end
  end

  // Between samples the bus shows the inverse of the last word, not a copy
  assign raw_valid = go;
  assign raw_data = go ? code : ~last;

  // Remember the last word sent
  always @(posedge clk) begin
    if (go) begin
      last <= code;
    end
  end
endmodule // aocal_fe_model

/* File: verification/aocal_top_tb.sv */
// Self-checking bench of the offset and gain correction stage
`timescale 1ns/1ps
`include "aocal_consts.svh"
module aocal_top_tb import aocal_pkg::*; ;
  localparam logic [2:0] a_ctl = `AOCAL_ADDR_CTRL;
  localparam logic [2:0] a_off = `AOCAL_ADDR_OFFSET;
  localparam logic [2:0] a_gain = `AOCAL_ADDR_GAIN;
  localparam logic [2:0] a_data = `AOCAL_ADDR_DATA;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [23:0] wdata = 24'h000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic go = 1'b0;
  logic [23:0] ext = 24'h000000;
  logic [23:0] rdata;
  logic [23:0] raw_data;
  logic raw_valid, in_short, in_ref, busy, res_valid;
  logic [15:0] result;
  logic [15:0] prev;
  logic [90:0] rows [11];
  int mismatches = 0;
  int compares = 0;

  // 50 MHz clock
  always #10 clk = ~clk;

  aocal_top dut_u (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .RAW_DATA(raw_data),
    .RAW_VALID(raw_valid), .INPUT_SHORT(in_short), .INPUT_REF(in_ref),
    .CAL_BUSY(busy), .RESULT(result), .RESULT_VALID(res_valid));
  aocal_fe_model fe_u (.clk(clk), .go(go), .ext_code(ext),
    .input_short(in_short), .input_ref(in_ref), .raw_data(raw_data),
    .raw_valid(raw_valid));

  // Shared comparison
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Flags in the order busy, short, reference
  task automatic flg(input logic [2:0] exp);
    chk({21'h0, busy, in_short, in_ref}, {21'h0, exp});
  endtask

  // Bus cycles start after an edge and end just after the taking edge
  task automatic wrt(input logic [2:0] a, input logic [23:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rdc(input logic [2:0] a, input logic [23:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask

  // One sample at the calibration pace; the model picks the input source
  task automatic smp(input logic [23:0] r);
    @(posedge clk);
    ext <= r;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    #1;
  endtask

  // Result lands one cycle after the sample is taken
  task automatic conv(input logic [23:0] r, input logic [15:0] e);
    smp(r);
    @(posedge clk);
    #1;
    chk({23'h0, res_valid}, 24'h000001);
    chk({8'h0, result}, {8'h0, e});
    @(posedge clk);
    #1;
    chk({23'h0, res_valid}, 24'h000000);
  endtask

  // Bounded wait for the divider to finish
  task automatic idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({23'h0, busy}, 24'h000000);
  endtask

  task automatic end_of_test();
    if (mismatches == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs well under 1000 cycles
  initial begin
    #(20 * 5000);
    mismatches++;
    end_of_test();
  end

  // Main sequence
  initial begin
    // Row: raw, offset, gain, amplifier gain, unipolar, result
    rows[0] = {24'h123456, 24'h000000, 24'h800000, 2'h0, 1'h0, 16'h1234};
    rows[1] = {24'h123456, 24'h003456, 24'h800000, 2'h1, 1'h0, 16'h2400};
    rows[2] = {24'hFF0000, 24'h000000, 24'h800000, 2'h2, 1'h0, 16'hFC00};
    rows[3] = {24'h400000, 24'h000000, 24'h800000, 2'h3, 1'h0, 16'h7FFF};
    rows[4] = {24'h800000, 24'h100000, 24'h800000, 2'h0, 1'h0, 16'h8000};
    rows[5] = {24'h000000, 24'hFF0000, 24'h400000, 2'h0, 1'h0, 16'h0080};
    rows[6] = {24'hFF0000, 24'h000000, 24'h800000, 2'h0, 1'h1, 16'h0000};
    rows[7] = {24'h123456, 24'h000000, 24'h800000, 2'h0, 1'h1, 16'h2468};
    rows[8] = {24'h7FFFFF, 24'h000000, 24'h800000, 2'h1, 1'h1, 16'hFFFF};
    rows[9] = {24'h100000, 24'h000000, 24'hFFFFFF, 2'h0, 1'h0, 16'h1FFF};
    // Gain below one half is accepted though a host should avoid it
    rows[10] = {24'h123456, 24'h000000, 24'h000000, 2'h3, 1'h0, 16'h0000};
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    prev = 16'h0000;
    for (int i = 0; i < 11; i++) begin
      wrt(a_off, rows[i][66:43]);
      wrt(a_gain, rows[i][42:19]);
      wrt(a_ctl, {21'h0, rows[i][16], rows[i][18:17]});
      chk({8'h0, result}, {8'h0, prev});
      conv(rows[i][90:67], rows[i][15:0]);
      prev = rows[i][15:0];
    end
    // Self offset; a second command while busy is dropped
    wrt(a_ctl, 24'h000008);
    flg(3'b110);
    wrt(a_ctl, 24'h000010);
    rdc(a_ctl, 24'h000048);
    smp(24'h555555);
    flg(3'b000);
    rdc(a_off, 24'h000100);
    chk({8'h0, result}, {8'h0, prev});
    // Self gain, then a full-scale conversion with the new values
    wrt(a_ctl, 24'h000010);
    flg(3'b101);
    smp(24'h555555);
    idle();
    rdc(a_gain, 24'h924924);
    conv(24'h700100, 16'h7FFF);
    // System calibration, offset first, host supplies the inputs
    wrt(a_ctl, 24'h000018);
    flg(3'b100);
    smp(24'hFFFFF8);
    rdc(a_off, 24'hFFFFF8);
    wrt(a_ctl, 24'h000020);
    flg(3'b100);
    smp(24'h7FFFF7);
    idle();
    rdc(a_gain, 24'h800001);
    // A reading far below full scale saturates the gain
    wrt(a_ctl, 24'h000020);
    smp(24'h000000);
    idle();
    rdc(a_gain, 24'hFFFFFF);
    // Unknown command, read-only result, unmapped address
    wrt(a_ctl, 24'h000028);
    flg(3'b000);
    wrt(a_data, 24'h00ABCD);
    rdc(a_data, 24'h007FFF);
    rdc(3'h5, 24'h000000);
    // Second reset in mid-run
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk({8'h0, result}, 24'h000000);
    rdc(a_off, 24'h000000);
    rdc(a_gain, 24'h800000);
    end_of_test();
  end
endmodule // aocal_top_tb
